// ===== hw/slc_defs.vh
// Constants of the segment display control block: offsets, fields, resets, timing.
`ifndef SLC_DEFS_VH
`define SLC_DEFS_VH

// Register byte offsets.
`define SLC_OFF_CTRL_A   8'h00
`define SLC_OFF_CTRL_B   8'h04
`define SLC_OFF_IRQ_STS  8'h08
`define SLC_OFF_IRQ_EN   8'h0C
`define SLC_OFF_IRQ_CLR  8'h10

// Control A fields.
`define SLC_A_EN         7
`define SLC_A_LPW        6
`define SLC_A_IF         4
`define SLC_A_IE         3
`define SLC_A_BL         0
`define SLC_A_WMASK      8'hC9

// Control B fields.
`define SLC_B_CS         7
`define SLC_B_HB         6
`define SLC_B_DUTY_HI    5
`define SLC_B_DUTY_LO    4
`define SLC_B_PM_HI      2
`define SLC_B_PM_LO      0
`define SLC_B_WMASK      8'hF7

// Interrupt status fields.
`define SLC_EV_FRAME     0
`define SLC_EV_BLANK     1
`define SLC_EV_W         2

// Reset values.
`define SLC_RST_A        8'h00
`define SLC_RST_B        8'h00

// Bias modes driven to the analog stage.
`define SLC_BIAS_STATIC  2'h0
`define SLC_BIAS_HALF    2'h1
`define SLC_BIAS_THIRD   2'h2

// Segment and common pin counts.
`define SLC_SEG_N        25
`define SLC_COM_N        4
`define SLC_SEG_BASE     13

// LCD clock ticks per frame when no frame rate logic trims it (K*N*D, K=8,N=16,D=1).
`define SLC_FRAME_TICKS  128

`endif

// ===== hw/slc_ctrl.v
// Control and status logic of the segment display controller, with AHB-Lite registers.
//
// Functional notes
// - Enable starts the driver; clearing it stops at once and frees every pin.
// - Waveform bit picks default or low-power waveform, applied at next frame.
// - Frame flag sets at each frame start, together with the data latch.
// - Interrupt requested when flag, enable and global enable set; vector clears flag.
// - Writing one to the flag position clears it; zero leaves it.
// - Low-power waveform sets the flag and latches data every second frame.
// - Blanking finishes the current frame, then drives all pins to ground.
// - Reserved bits of both control registers always read zero.
// - Clock select picks system clock or async source, chosen by external enable.
// - Bias bit gives third bias when zero, half bias when one.
// - Duty field selects static, 1/2, 1/3 or 1/4 and common pins used.
// - Static duty forces static bias regardless of the bias bit.
// - Port mask selects 13 to 25 segment pins in steps.
// - Segment pins beyond the mask stay with the ordinary port logic.
// - Display memory, blanking, waveform and contrast are sampled before each frame.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`include "slc_defs.vh"

module slc_ctrl #(
   parameter FRAME_TICKS = `SLC_FRAME_TICKS,
   parameter MEM_W       = 100
)(
   input  wire               hclk,
   input  wire               hresetn,
   input  wire               hsel,
   input  wire [7:0]         haddr,
   input  wire [1:0]         htrans,
   input  wire               hwrite,
   input  wire [2:0]         hsize,
   input  wire [31:0]        hwdata,
   input  wire               hready,
   output reg  [31:0]        hrdata_ff,
   output reg                hreadyout_ff,
   output reg                hresp_ff,
   input  wire               tosc_tick,
   input  wire               ext_clk_tick,
   input  wire               ext_clock_input_enable,
   input  wire               cpu_int_enable,
   input  wire               irq_vector_ack,
   input  wire [MEM_W-1:0]   display_mem_in,
   input  wire [3:0]         contrast_in,
   output reg  [MEM_W-1:0]   display_mem_lat_ff,
   output reg  [3:0]         contrast_lat_ff,
   output reg                frame_irq_ff,
   output reg                irq_ff,
   output reg                frame_start_ff,
   output reg                low_power_active_ff,
   output reg                blank_active_ff,
   output reg  [1:0]         bias_mode_ff,
   output reg  [1:0]         duty_active_ff,
   output reg  [`SLC_COM_N-1:0] com_lcd_own_ff,
   output reg  [`SLC_SEG_N-1:0] seg_lcd_own_ff
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Number of segment pins given to the driver by a port mask code.
   function [4:0] seg_count;
      input [2:0] pm;
      begin
         if (pm < 3'h6)
            seg_count = 5'd13 + {1'b0, pm, 1'b0};
         else
            seg_count = 5'd18 + {2'b00, pm};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register state.

   reg                 en_ff;
   reg                 lpw_ff;
   reg                 flag_ff;
   reg                 ie_ff;
   reg                 bl_ff;
   reg  [7:0]          ctrl_b_ff;
   reg  [`SLC_EV_W-1:0] sts_ff;
   reg  [`SLC_EV_W-1:0] sts_en_ff;
   reg                 wr_pend_ff;
   reg                 rd_pend_ff;
   reg  [7:0]          addr_ff;
   reg  [15:0]         tick_cnt_ff;
   reg                 odd_frame_ff;

   reg                 nxt_flag;
   reg  [`SLC_EV_W-1:0] nxt_sts;
   reg  [31:0]         rd_val;
   reg                 lcd_tick;
   reg                 raw_frame;
   reg                 eff_frame;
   reg                 blank_rise;
   integer             i;

   wire                addr_ok = hsel & hready & htrans[1];
   wire [1:0]          duty    = ctrl_b_ff[`SLC_B_DUTY_HI:`SLC_B_DUTY_LO];
   wire [2:0]          pmask   = ctrl_b_ff[`SLC_B_PM_HI:`SLC_B_PM_LO];
   wire [4:0]          seg_n   = seg_count(pmask);
   wire                wr_a    = wr_pend_ff & (addr_ff == `SLC_OFF_CTRL_A);
   wire                wr_b    = wr_pend_ff & (addr_ff == `SLC_OFF_CTRL_B);
   wire                wr_en   = wr_pend_ff & (addr_ff == `SLC_OFF_IRQ_EN);
   wire                wr_clr  = wr_pend_ff & (addr_ff == `SLC_OFF_IRQ_CLR);

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: writes take no wait state, reads take one.

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff   <= 1'b0;
         rd_pend_ff   <= 1'b0;
         addr_ff      <= 8'h00;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
         hrdata_ff    <= 32'h00000000;
      end
      else
      begin
         wr_pend_ff <= addr_ok & hwrite;
         rd_pend_ff <= addr_ok & ~hwrite;
         if (addr_ok)
            addr_ff <= {haddr[7:2], 2'b00};
         if (addr_ok & ~hwrite)
            hreadyout_ff <= 1'b0;  // Wait state lets read data come from a flop.
         else if (rd_pend_ff)
         begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= rd_val;
         end
      end
   end

   // Read decode; reserved bits and unmapped words read zero.
   always @*
   begin
      rd_val = 32'h00000000;
      if (addr_ff == `SLC_OFF_CTRL_A)
      begin
         rd_val[`SLC_A_EN]  = en_ff;
         rd_val[`SLC_A_LPW] = lpw_ff;
         rd_val[`SLC_A_IF]  = flag_ff;
         rd_val[`SLC_A_IE]  = ie_ff;
         rd_val[`SLC_A_BL]  = bl_ff;
      end
      else if (addr_ff == `SLC_OFF_CTRL_B)
         rd_val[7:0] = ctrl_b_ff & `SLC_B_WMASK;
      else if (addr_ff == `SLC_OFF_IRQ_STS)
         rd_val[`SLC_EV_W-1:0] = sts_ff;
      else if (addr_ff == `SLC_OFF_IRQ_EN)
         rd_val[`SLC_EV_W-1:0] = sts_en_ff;
      else
         rd_val = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // LCD clock source and frame pulse.

   // Pick the LCD clock enable from the selected source.
   always @*
   begin
      if (!ctrl_b_ff[`SLC_B_CS])
         lcd_tick = 1'b1;
      else if (ext_clock_input_enable)
         lcd_tick = ext_clk_tick;
      else
         lcd_tick = tosc_tick;
   end

   // Frame counter; held in reset while disabled so it restarts cleanly.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tick_cnt_ff <= 16'h0000;
      else if (!en_ff)
         tick_cnt_ff <= 16'h0000;
      else if (lcd_tick)
      begin
         if (tick_cnt_ff == FRAME_TICKS[15:0] - 16'h0001)
            tick_cnt_ff <= 16'h0000;
         else
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
   end

   // Raw frame edge, then gated to every second frame in low-power mode.
   always @*
   begin
      raw_frame = en_ff & lcd_tick & (tick_cnt_ff == FRAME_TICKS[15:0] - 16'h0001);
      eff_frame = raw_frame & (~low_power_active_ff | odd_frame_ff);
      blank_rise = eff_frame & bl_ff & ~blank_active_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers and the frame flag.

   // Flag: hardware set wins over software or vector clear.
   always @*
   begin
      nxt_flag = flag_ff;
      if (wr_a & hwdata[`SLC_A_IF])
         nxt_flag = 1'b0;
      if (irq_vector_ack)
         nxt_flag = 1'b0;
      if (eff_frame)
         nxt_flag = 1'b1;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en_ff     <= 1'b0;
         lpw_ff    <= 1'b0;
         flag_ff   <= 1'b0;
         ie_ff     <= 1'b0;
         bl_ff     <= 1'b0;
         ctrl_b_ff <= `SLC_RST_B;
      end
      else
      begin
         flag_ff <= nxt_flag;
         if (wr_a)
         begin
            en_ff  <= hwdata[`SLC_A_EN];
            lpw_ff <= hwdata[`SLC_A_LPW];
            ie_ff  <= hwdata[`SLC_A_IE];
            bl_ff  <= hwdata[`SLC_A_BL];
         end
         if (wr_b)
            ctrl_b_ff <= hwdata[7:0] & `SLC_B_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shadowed settings, latched at the frame pulse.

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         low_power_active_ff <= 1'b0;
         odd_frame_ff        <= 1'b0;
         blank_active_ff     <= 1'b0;
         display_mem_lat_ff  <= {MEM_W{1'b0}};
         contrast_lat_ff     <= 4'h0;
         frame_start_ff      <= 1'b0;
      end
      else
      begin
         frame_start_ff <= eff_frame;
         if (!en_ff)
         begin
            odd_frame_ff    <= 1'b0;
            blank_active_ff <= 1'b0;
         end
         else if (raw_frame)
         begin
            odd_frame_ff        <= ~odd_frame_ff;
            low_power_active_ff <= lpw_ff;
         end
         if (eff_frame)
         begin
            blank_active_ff    <= bl_ff;
            display_mem_lat_ff <= display_mem_in;
            contrast_lat_ff    <= contrast_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin ownership, duty and bias.

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         com_lcd_own_ff <= {`SLC_COM_N{1'b0}};
         seg_lcd_own_ff <= {`SLC_SEG_N{1'b0}};
         bias_mode_ff   <= `SLC_BIAS_STATIC;
         duty_active_ff <= 2'h0;
      end
      else
      begin
         duty_active_ff <= duty;
         if (duty == 2'h0)
            bias_mode_ff <= `SLC_BIAS_STATIC;
         else if (ctrl_b_ff[`SLC_B_HB])
            bias_mode_ff <= `SLC_BIAS_HALF;
         else
            bias_mode_ff <= `SLC_BIAS_THIRD;
         for (i = 0; i < `SLC_COM_N; i = i + 1)
            com_lcd_own_ff[i] <= en_ff & (i <= duty);
         for (i = 0; i < `SLC_SEG_N; i = i + 1)
            seg_lcd_own_ff[i] <= en_ff & (i < seg_n);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: frame vector request and the sticky event register.

   // Sticky events; a new event wins over a clear in the same cycle.
   always @*
   begin
      nxt_sts = sts_ff;
      if (wr_clr)
         nxt_sts = nxt_sts & ~hwdata[`SLC_EV_W-1:0];
      if (eff_frame)
         nxt_sts[`SLC_EV_FRAME] = 1'b1;
      if (blank_rise)
         nxt_sts[`SLC_EV_BLANK] = 1'b1;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sts_ff       <= {`SLC_EV_W{1'b0}};
         sts_en_ff    <= {`SLC_EV_W{1'b0}};
         frame_irq_ff <= 1'b0;
         irq_ff       <= 1'b0;
      end
      else
      begin
         sts_ff <= nxt_sts;
         if (wr_en)
            sts_en_ff <= hwdata[`SLC_EV_W-1:0];
         frame_irq_ff <= nxt_flag & ie_ff & cpu_int_enable;
         irq_ff       <= |(nxt_sts & sts_en_ff);
      end
   end

endmodule // slc_ctrl

// ===== verification/slc_ctrl_props.sv
// Concurrent checks on the ports of the segment display control block.
`include "slc_defs.vh"
module slc_ctrl_props #(
   parameter MEM_W = 100
)(
   input logic                  hclk,
   input logic                  hresetn,
   input logic                  hsel,
   input logic [1:0]            htrans,
   input logic                  hwrite,
   input logic                  hready,
   input logic                  hreadyout_ff,
   input logic                  hresp_ff,
   input logic                  cpu_int_enable,
   input logic                  irq_vector_ack,
   input logic [MEM_W-1:0]      display_mem_lat_ff,
   input logic                  frame_irq_ff,
   input logic                  frame_start_ff,
   input logic [1:0]            bias_mode_ff,
   input logic [1:0]            duty_active_ff,
   input logic [`SLC_COM_N-1:0] com_lcd_own_ff,
   input logic [`SLC_SEG_N-1:0] seg_lcd_own_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus answers: a read waits exactly one cycle, and the response is always OKAY.
   a_resp_okay: assert property (hresp_ff == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
      |=> !hreadyout_ff ##1 hreadyout_ff) else $error("read wait not one cycle");

   ////////////////////////////////////////////////////////////////////////////////
   // Frame pulse, latch moment and interrupt gating.
   a_frame_single: assert property (frame_start_ff |=> !frame_start_ff)
      else $error("frame pulse longer than one cycle");
   a_latch_at_frame: assert property (!$stable(display_mem_lat_ff) |-> ##[0:1] frame_start_ff)
      else $error("display data latched outside a frame start");
   a_irq_gate: assert property (frame_irq_ff |-> $past(cpu_int_enable))
      else $error("frame interrupt without global enable");
   a_ack_clears: assert property (irq_vector_ack |-> ##[1:2] !frame_irq_ff)
      else $error("vector taken but frame interrupt stays");

   ////////////////////////////////////////////////////////////////////////////////
   // Pin ownership and bias follow the duty and mask settings.
   a_static_bias: assert property (duty_active_ff == 2'h0 |-> bias_mode_ff == `SLC_BIAS_STATIC)
      else $error("static duty without static bias");
   a_com_duty: assert property (com_lcd_own_ff != 4'h0
      |-> com_lcd_own_ff == (4'h2 << duty_active_ff) - 4'h1)
      else $error("common pins do not match duty");
   a_seg_range: assert property (seg_lcd_own_ff != 25'h0 |-> seg_lcd_own_ff[12:0] == 13'h1FFF
      && (seg_lcd_own_ff & (seg_lcd_own_ff + 25'h1)) == 25'h0)
      else $error("segment pins not a contiguous range");
   a_own_together: assert property ((seg_lcd_own_ff == 25'h0) == (com_lcd_own_ff == 4'h0))
      else $error("segment and common ownership disagree");
endmodule // slc_ctrl_props

bind slc_ctrl slc_ctrl_props #(.MEM_W(MEM_W)) u_props (.*);

// ===== verification/slc_glass.sv
// Passive display glass model that remembers whether it was left charged.
module slc_glass (
   input logic        hclk,
   input logic        blank_active_ff,
   input logic [24:0] seg_lcd_own_ff,
   output logic       dc_left
);
   timeunit 1ns;
   timeprecision 1ps;

   // Glass keeps charge unless grounded on the last driven cycle.
   initial dc_left = 1'b0;
   always @(posedge hclk)
      if (seg_lcd_own_ff != 25'h0)
         dc_left <= !blank_active_ff;
endmodule // slc_glass

// ===== verification/tb.sv
// Testbench of the segment display control block.
`include "slc_defs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hwrite, tosc_tick, ext_clk_tick, ext_clock_input_enable;
   logic cpu_int_enable, irq_vector_ack, hreadyout_ff, hresp_ff, frame_irq_ff, irq_ff;
   logic frame_start_ff, low_power_active_ff, blank_active_ff, dc_left;
   logic [7:0]  haddr;
   logic [1:0]  htrans, bias_mode_ff, duty_active_ff, eb;
   logic [31:0] hwdata, hrdata_ff;
   logic [99:0] display_mem_in, display_mem_lat_ff;
   logic [3:0]  contrast_in, contrast_lat_ff, com_lcd_own_ff;
   logic [24:0] seg_lcd_own_ff;
   wire         hsel = 1'b1;
   wire [2:0]   hsize = 3'h2;
   wire         hready = hreadyout_ff;
   int          error_cnt, compares, fcnt, n0, ns;

   slc_ctrl #(.FRAME_TICKS(8)) DUT (.*);
   slc_glass u_glass (.*);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, frame pulse counter and watchdog.
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (frame_start_ff === 1'b1)
         fcnt <= fcnt + 1;
   initial
   begin
      #20000;
      error_cnt++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, bus and tick tasks.
   task chk(input [99:0] s, input [99:0] e, input string n);
      compares++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task rc(input [7:0] a, input [31:0] e, input string n);
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hready !== 1'b1);
      chk(hrdata_ff, e, n);
   endtask
   task tk(input bit x, input int n);
      repeat (n)
      begin
         @(posedge hclk);
         {ext_clk_tick, tosc_tick} <= x ? 2'h2 : 2'h1;
      end
      @(posedge hclk);
      {ext_clk_tick, tosc_tick} <= 2'h0;
      repeat (3) @(posedge hclk);
   endtask
   task finish_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      {hresetn, hwrite, tosc_tick, ext_clk_tick, ext_clock_input_enable} = 5'h0;
      {cpu_int_enable, irq_vector_ack, haddr, htrans, hwdata} = 44'h0;
      display_mem_in = {25{4'hA}};
      contrast_in = 4'h5;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rc(8'h00, 32'h00, "ctrl_a");
      rc(8'h04, 32'h00, "ctrl_b");
      wr(8'h04, 32'hFF);
      rc(8'h04, 32'hF7, "ctrl_b_rsv");
      rc(8'h20, 32'h00, "unmapped");
      wr(8'h00, 32'h88);
      for (int c = 0; c < 8; c++)
      begin
         ns = (c < 6) ? 13 + 2 * c : c + 18;
         eb = (c[1:0] == 2'h0) ? `SLC_BIAS_STATIC : (c[2] ? `SLC_BIAS_HALF : `SLC_BIAS_THIRD);
         wr(8'h04, {24'h0, 1'b1, c[2], c[1:0], 1'b0, c[2:0]});
         repeat (2) @(posedge hclk);
         chk(duty_active_ff, c[1:0], "duty");
         chk(com_lcd_own_ff, (5'h2 << c[1:0]) - 5'h1, "com_own");
         chk(seg_lcd_own_ff, (26'h1 << ns) - 26'h1, "seg_own");
         chk(bias_mode_ff, eb, "bias");
      end
      tk(1'b0, 8);
      rc(8'h00, 32'h98, "flag_set");
      chk(display_mem_lat_ff, display_mem_in, "mem_latch");
      chk(contrast_lat_ff, contrast_in, "contrast");
      rc(8'h08, 32'h01, "irq_status");
      wr(8'h0C, 32'h01);
      repeat (2) @(posedge hclk);
      chk(irq_ff, 1'b1, "irq_on");
      chk(frame_irq_ff, 1'b0, "frame_irq_gated");
      wr(8'h10, 32'h01);
      repeat (2) @(posedge hclk);
      chk(irq_ff, 1'b0, "irq_cleared");
      cpu_int_enable <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(frame_irq_ff, 1'b1, "frame_irq");
      irq_vector_ack <= 1'b1;
      @(posedge hclk);
      irq_vector_ack <= 1'b0;
      rc(8'h00, 32'h88, "ack_clear");
      wr(8'h0C, 32'h00);
      tk(1'b0, 8);
      chk(irq_ff, 1'b0, "irq_masked");
      wr(8'h00, 32'h88);
      rc(8'h00, 32'h98, "flag_kept");
      wr(8'h00, 32'h98);
      rc(8'h00, 32'h88, "flag_cleared");
      ext_clock_input_enable <= 1'b1;
      tk(1'b0, 8);
      rc(8'h00, 32'h88, "tosc_ignored");
      tk(1'b1, 8);
      rc(8'h00, 32'h98, "ext_frame");
      ext_clock_input_enable <= 1'b0;
      wr(8'h00, 32'hD0);
      tk(1'b0, 8);
      n0 = fcnt;
      tk(1'b0, 32);
      chk(fcnt - n0, 2, "lp_frames");
      chk(low_power_active_ff, 1'b1, "lp_active");
      wr(8'h00, 32'h91);
      chk(blank_active_ff, 1'b0, "blank_wait");
      tk(1'b0, 16);
      chk(blank_active_ff, 1'b1, "blank_on");
      rc(8'h08, 32'h03, "blank_event");
      wr(8'h00, 32'h00);
      repeat (2) @(posedge hclk);
      chk(seg_lcd_own_ff, 25'h0, "seg_free");
      chk(com_lcd_own_ff, 4'h0, "com_free");
      chk(dc_left, 1'b0, "glass_discharged");
      finish_test();
   end
endmodule // tb
